// *** rtl/sdc_map.svh ***
/*
  Register offsets, field positions, reset values and timing counts of the
  sinc3 decimator with clock selection.
  Assumes it is included by its bare name by every file that needs it.
*/
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH

// ==========================================================================
// Register offsets on the 4-bit register port.
// ==========================================================================
`define SDC_ADDR_STATUS     4'h0
`define SDC_ADDR_CONFIG     4'h1
`define SDC_ADDR_CONTROL    4'h2
`define SDC_ADDR_LEADSTAT   4'h8
`define SDC_ADDR_CH1_HI     4'hc
`define SDC_ADDR_CH1_LO     4'hd
`define SDC_ADDR_CH2_HI     4'he
`define SDC_ADDR_CH2_LO     4'hf

// ==========================================================================
// Field positions and reset values.
// ==========================================================================
`define SDC_CFG_RATE_HI     2
`define SDC_CFG_RATE_LO     0
`define SDC_CFG_OSC_OE      5
`define SDC_CFG_RESET       8'h02
`define SDC_CTL_START       0
`define SDC_LEAD_FREQ_SEL   6
`define SDC_LEAD_RESET      1'b0
`define SDC_STAT_SETTLED    0
`define SDC_STAT_OVERRUN    1
`define SDC_STAT_EMPTY      2
`define SDC_STAT_FULL       3

// ==========================================================================
// Rates and derived cycle counts.
// ==========================================================================
`define SDC_CLK_SYS_HZ      25000000
`define SDC_MCLK_LO_HZ      512000
`define SDC_MCLK_HI_HZ      2048000
`define SDC_MOD_HZ          128000
`define SDC_OSC_HALF_LO     (`SDC_CLK_SYS_HZ / (2 * `SDC_MCLK_LO_HZ))
`define SDC_OSC_HALF_HI     (`SDC_CLK_SYS_HZ / (2 * `SDC_MCLK_HI_HZ))
`define SDC_MOD_DIV_LO      (`SDC_MCLK_LO_HZ / `SDC_MOD_HZ)
`define SDC_MOD_DIV_HI      (`SDC_MCLK_HI_HZ / `SDC_MOD_HZ)
`define SDC_SETTLE_PERIODS  2'd3
`define SDC_LOG2_MAX        4'd10
`define SDC_LOG2_MIN        4'd4
`define SDC_FULL_SHIFT      5'd15
`define SDC_POS_CLIP        16'h7fff
`define SDC_NEG_CLIP        16'h8000

`endif

// *** rtl/sdc_pkg.sv ***
/*
  Types shared by the sinc3 decimator files.
  Assumes nothing of its surroundings.
*/
package sdc_pkg;
  // Conversion sequencing, Gray coded along idle, settle, run.
  typedef enum logic [1:0]
  {
    SDC_IDLE   = 2'b00,
    SDC_SETTLE = 2'b01,
    SDC_RUN    = 2'b11
  } sdc_state_type;
endpackage

// *** rtl/sdc_fifo.sv ***
/*
  Synchronous FIFO with valid and ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sdc_map.svh"

module sdc_fifo
  import sdc_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
)
(
  // Clock and reset.
  input  wire logic             clk_sys,
  input  wire logic             srst,
  // Filling side.
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Draining side.
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0]      count_q, count_d;
  logic             push, pop;

  // ========================================================================
  // Pointer and count update.
  // ========================================================================
  always_comb
  begin
    inReady  = (count_q != (AW+1)'(DEPTH));
    outValid = (count_q != '0);
    push     = inValid && inReady;
    pop      = outValid && outReady;
    wrPtr_d  = push ? AW'(wrPtr_q + 1'b1) : wrPtr_q;
    rdPtr_d  = pop ? AW'(rdPtr_q + 1'b1) : rdPtr_q;
    count_d  = count_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // Storage writes; read data is the head word, read combinationally at the read pointer.
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wrPtr_q] <= inData;
  end

  assign outData = mem[rdPtr_q];
endmodule
`default_nettype wire

// *** rtl/sdc_sinc3.sv ***
/*
  One channel of a third-order sinc decimator: three integrators at the
  modulator rate, three differentiators at the output rate, then scaling
  and clipping to a 16-bit twos-complement word.
  Assumes the decimation tick coincides with a modulator tick.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sdc_map.svh"

module sdc_sinc3
  import sdc_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // Control.
  input  wire logic        clear,
  input  wire logic        modTick,
  input  wire logic        decTick,
  input  wire logic [3:0]  log2Ratio,
  // Modulator bit and result.
  input  wire logic        modBit,
  output logic [15:0]      sampleOut
);
  logic signed [31:0] int1_q, int2_q, int3_q, int1_d, int2_d, int3_d;
  logic signed [31:0] dly1_q, dly2_q, dly3_q, dly1_d, dly2_d, dly3_d;
  logic signed [31:0] comb1, comb2, comb3, scaled;
  logic        [15:0] sample_q, sample_d;
  logic        [4:0]  shift;

  // ========================================================================
  // Cascaded moving sums; a 1 counts +1 and a 0 counts -1.
  // ========================================================================
  always_comb
  begin
    int1_d = int1_q;
    int2_d = int2_q;
    int3_d = int3_q;
    dly1_d = dly1_q;
    dly2_d = dly2_q;
    dly3_d = dly3_q;
    sample_d = sample_q;
    if (modTick)
    begin
      int1_d = int1_q + (modBit ? 32'sh1 : -32'sh1);
      int2_d = int2_q + int1_q;
      int3_d = int3_q + int2_q;
    end
    comb1 = int3_d - dly1_q;  // Includes this tick's sum so the first word is exact.
    comb2 = comb1 - dly2_q;
    comb3 = comb2 - dly3_q;
    shift = 5'(3 * log2Ratio) - `SDC_FULL_SHIFT;
    if (log2Ratio > `SDC_LOG2_MIN)
      scaled = comb3 >>> shift;
    else
      scaled = comb3 <<< (`SDC_FULL_SHIFT - 5'(3 * log2Ratio));
    if (decTick)
    begin
      dly1_d = int3_d;
      dly2_d = comb1;
      dly3_d = comb2;
      if (scaled > 32'sh7fff)
        sample_d = `SDC_POS_CLIP;
      else if (scaled < -32'sh8000)
        sample_d = `SDC_NEG_CLIP;
      else
        sample_d = scaled[15:0];
    end
    if (clear)
    begin
      int1_d = '0;
      int2_d = '0;
      int3_d = '0;
      dly1_d = '0;
      dly2_d = '0;
      dly3_d = '0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      int1_q <= '0;
      int2_q <= '0;
      int3_q <= '0;
      dly1_q <= '0;
      dly2_q <= '0;
      dly3_q <= '0;
      sample_q <= '0;
    end
    else
    begin
      int1_q <= int1_d;
      int2_q <= int2_d;
      int3_q <= int3_d;
      dly1_q <= dly1_d;
      dly2_q <= dly2_d;
      dly3_q <= dly3_d;
      sample_q <= sample_d;
    end
  end

  assign sampleOut = sample_q;
endmodule
`default_nettype wire

// *** rtl/sdc_top.sv ***
/*
  Two-channel sinc3 decimator with master-clock selection, modulator-rate
  divider, settling control, result registers and an output FIFO.
  Assumes all inputs are synchronous to clk_sys and that the clock pin is
  resolved from its output enable outside this module.
*/
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "sdc_map.svh"

// What this block does
// - Third-order sinc filter on every channel.
// - One data-rate field sets all channels.
// - One input per modulator tick, decimate by N.
// - Moving sums give notches at output rate.
// - Step response settles after three output periods.
// - Withhold first output until settling has passed.
// - Strap low external clock, high internal.
// - Oscillator enable drives clock pin when strapped high, else tristate.
// - Lead-status bit 6 picks 512k or 2.048M.
// - Modulator runs at 128 kHz either way.
// - Frequency select resets to 512 kHz.
// - Divide master clock by 4 or 16.
// - Clip outputs at 7FFFh and 8000h.
module sdc_top
  import sdc_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // Register port.
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [7:0]       regRdData,
  // Clock source strap and clock pin.
  input  wire logic        clock_source_strap,
  input  wire logic        clkPinIn,
  output logic             clkPinOut,
  output logic             clkPinOe,
  // Modulator bitstreams.
  input  wire logic [1:0]  modBits,
  // New-data strobe and result stream.
  output logic             newData,
  output logic             outValid,
  input  wire logic        outReady,
  output logic [31:0]      outData
);
  // Software-visible state.
  logic [7:0]    primary_config_reg_q, primary_config_reg_d;
  logic          startCmd_q, startCmd_d;
  logic          freqSel_q, freqSel_d;
  logic          overrun_q, overrun_d;
  logic [7:0]    rdData_q, rdData_d;
  // Clocking state.
  logic [4:0]    oscCnt_q, oscCnt_d;
  logic          oscLevel_q, oscLevel_d;
  logic          clkPinPrev_q, clkPinPrev_d;
  logic [3:0]    modDiv_q, modDiv_d;
  logic [9:0]    decCnt_q, decCnt_d;
  // Conversion state.
  sdc_state_type state_q, state_d;
  logic [1:0]    settleCnt_q, settleCnt_d;
  logic          decTickDly_q, decTickDly_d;
  logic [31:0]   result_q, result_d;
  logic          newData_q, newData_d;
  // Combinational helpers.
  logic          oscTick, mclkTick, modTick, decTick, clearFilt;
  logic          rateWrite, publish, fifoReady;
  logic [4:0]    oscHalf;
  logic [3:0]    modDivLast, log2Ratio;
  logic [9:0]    decLast;
  logic [2:0]    rateField;
  logic [15:0]   ch1Sample, ch2Sample;
  logic [7:0]    leadStatus, statusReg;

  // ========================================================================
  // Register writes.
  // ========================================================================
  // Config, control and frequency select are written by software; the
  // overrun flag is set by hardware and cleared by a status read.
  always_comb
  begin
    primary_config_reg_d = primary_config_reg_q;
    startCmd_d = startCmd_q;
    freqSel_d  = freqSel_q;
    rateWrite  = 1'b0;
    if (regWr)
    begin
      unique case (regAddr)
        `SDC_ADDR_CONFIG:
        begin
          primary_config_reg_d = regWrData;
          rateWrite = (regWrData[`SDC_CFG_RATE_HI:`SDC_CFG_RATE_LO] !=
                       primary_config_reg_q[`SDC_CFG_RATE_HI:`SDC_CFG_RATE_LO]);
        end
        `SDC_ADDR_CONTROL:  startCmd_d = regWrData[`SDC_CTL_START];
        `SDC_ADDR_LEADSTAT: freqSel_d  = regWrData[`SDC_LEAD_FREQ_SEL];
        default:            ;
      endcase
    end
    overrun_d = overrun_q;
    if (regRd && regAddr == `SDC_ADDR_STATUS)
      overrun_d = 1'b0;
    if (newData_q && !fifoReady)
      overrun_d = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      primary_config_reg_q <= `SDC_CFG_RESET;
      startCmd_q <= 1'b0;
      freqSel_q  <= `SDC_LEAD_RESET;
      overrun_q  <= 1'b0;
    end
    else
    begin
      primary_config_reg_q <= primary_config_reg_d;
      startCmd_q <= startCmd_d;
      freqSel_q  <= freqSel_d;
      overrun_q  <= overrun_d;
    end
  end

  // ========================================================================
  // Register reads, answered one cycle after the read strobe.
  // ========================================================================
  always_comb
  begin
    leadStatus = 8'h00;
    leadStatus[`SDC_LEAD_FREQ_SEL] = freqSel_q;
    statusReg = 8'h00;
    statusReg[`SDC_STAT_SETTLED] = (state_q == SDC_RUN);
    statusReg[`SDC_STAT_OVERRUN] = overrun_q;
    statusReg[`SDC_STAT_EMPTY]   = !outValid;
    statusReg[`SDC_STAT_FULL]    = !fifoReady;
    rdData_d = 8'h00;
    if (regRd)
    begin
      unique case (regAddr)
        `SDC_ADDR_STATUS:   rdData_d = statusReg;
        `SDC_ADDR_CONFIG:   rdData_d = primary_config_reg_q;
        `SDC_ADDR_CONTROL:  rdData_d = {7'h00, startCmd_q};
        `SDC_ADDR_LEADSTAT: rdData_d = leadStatus;
        `SDC_ADDR_CH1_HI:   rdData_d = result_q[31:24];
        `SDC_ADDR_CH1_LO:   rdData_d = result_q[23:16];
        `SDC_ADDR_CH2_HI:   rdData_d = result_q[15:8];
        `SDC_ADDR_CH2_LO:   rdData_d = result_q[7:0];
        default:            rdData_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      rdData_q <= 8'h00;
    else
      rdData_q <= rdData_d;
  end

  assign regRdData = rdData_q;

  // ========================================================================
  // Master clock: internal oscillator or clock pin, then modulator divider.
  // ========================================================================
  // The oscillator follows the frequency select so the modulator divider
  // sees the same master rate that an external clock would supply.
  always_comb
  begin
    oscHalf = freqSel_q ? 5'(`SDC_OSC_HALF_HI) : 5'(`SDC_OSC_HALF_LO);
    oscTick = 1'b0;
    oscCnt_d = oscCnt_q + 5'd1;
    oscLevel_d = oscLevel_q;
    if (oscCnt_q >= oscHalf - 5'd1)
    begin
      oscCnt_d = 5'd0;
      oscLevel_d = !oscLevel_q;
      oscTick = !oscLevel_q;
    end
    clkPinPrev_d = clkPinIn;
    mclkTick = clock_source_strap ? oscTick : (clkPinIn && !clkPinPrev_q);
    modDivLast = freqSel_q ? 4'(`SDC_MOD_DIV_HI - 1) : 4'(`SDC_MOD_DIV_LO - 1);
    modTick = 1'b0;
    modDiv_d = modDiv_q;
    if (mclkTick)
    begin
      if (modDiv_q >= modDivLast)
      begin
        modDiv_d = 4'd0;
        modTick = 1'b1;
      end
      else
        modDiv_d = modDiv_q + 4'd1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      oscCnt_q     <= 5'd0;
      oscLevel_q   <= 1'b0;
      clkPinPrev_q <= 1'b0;
      modDiv_q     <= 4'd0;
    end
    else
    begin
      oscCnt_q     <= oscCnt_d;
      oscLevel_q   <= oscLevel_d;
      clkPinPrev_q <= clkPinPrev_d;
      modDiv_q     <= modDiv_d;
    end
  end

  // The pin is driven only with the internal oscillator and its enable set.
  assign clkPinOe  = clock_source_strap && primary_config_reg_q[`SDC_CFG_OSC_OE];
  assign clkPinOut = clkPinOe && oscLevel_q;

  // ========================================================================
  // Decimation count and conversion sequencing.
  // ========================================================================
  // Rate code 0 is the longest ratio (1024); codes 6 and 7 give 16.
  always_comb
  begin
    rateField = primary_config_reg_q[`SDC_CFG_RATE_HI:`SDC_CFG_RATE_LO];
    log2Ratio = (rateField >= 3'd6) ? `SDC_LOG2_MIN : (`SDC_LOG2_MAX - 4'(rateField));
    decLast   = 10'((11'd1 << log2Ratio) - 11'd1);
    decTick   = modTick && (decCnt_q == decLast);
    clearFilt = (state_q == SDC_IDLE) || rateWrite;
    decCnt_d  = decCnt_q;
    if (clearFilt)
      decCnt_d = 10'd0;
    else if (modTick)
      decCnt_d = decTick ? 10'd0 : decCnt_q + 10'd1;
  end

  // Outputs are published only once three full periods have filled the
  // differentiator chain; a start or a rate change goes back to settling.
  always_comb
  begin
    state_d = state_q;
    settleCnt_d = settleCnt_q;
    decTickDly_d = decTick && !clearFilt;
    unique case (state_q)
      SDC_IDLE:
      begin
        settleCnt_d = 2'd0;
        if (startCmd_q)
          state_d = SDC_SETTLE;
      end
      SDC_SETTLE:
      begin
        if (decTick)
          settleCnt_d = settleCnt_q + 2'd1;
        if (decTickDly_q && settleCnt_q == `SDC_SETTLE_PERIODS)
          state_d = SDC_RUN;
      end
      SDC_RUN:      ;
      default:      state_d = SDC_IDLE;
    endcase
    if (!startCmd_q)
      state_d = SDC_IDLE;
    else if (rateWrite)
    begin
      state_d = SDC_SETTLE;
      settleCnt_d = 2'd0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      decCnt_q     <= 10'd0;
      state_q      <= SDC_IDLE;
      settleCnt_q  <= 2'd0;
      decTickDly_q <= 1'b0;
    end
    else
    begin
      decCnt_q     <= decCnt_d;
      state_q      <= state_d;
      settleCnt_q  <= settleCnt_d;
      decTickDly_q <= decTickDly_d;
    end
  end

  // ========================================================================
  // Filters, result register and strobe.
  // ========================================================================
  sdc_sinc3 u_ch1
  (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .clear     (clearFilt),
    .modTick   (modTick),
    .decTick   (decTick),
    .log2Ratio (log2Ratio),
    .modBit    (modBits[0]),
    .sampleOut (ch1Sample)
  );

  sdc_sinc3 u_ch2
  (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .clear     (clearFilt),
    .modTick   (modTick),
    .decTick   (decTick),
    .log2Ratio (log2Ratio),
    .modBit    (modBits[1]),
    .sampleOut (ch2Sample)
  );

  // Both channels update on the same tick, so one latch captures a pair.
  always_comb
  begin
    publish = decTickDly_q && !rateWrite && startCmd_q &&
              ((state_q == SDC_RUN) ||
               (state_q == SDC_SETTLE && settleCnt_q == `SDC_SETTLE_PERIODS));
    result_d = publish ? {ch1Sample, ch2Sample} : result_q;
    newData_d = publish;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      result_q  <= 32'h0000_0000;
      newData_q <= 1'b0;
    end
    else
    begin
      result_q  <= result_d;
      newData_q <= newData_d;
    end
  end

  assign newData = newData_q;

  // A pair that finds the FIFO full is dropped and flagged as overrun.
  sdc_fifo #(.WIDTH(32), .DEPTH(32)) u_fifo
  (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .inValid  (newData_q),
    .inReady  (fifoReady),
    .inData   (result_q),
    .outValid (outValid),
    .outReady (outReady),
    .outData  (outData)
  );
endmodule
`default_nettype wire

// *** test/sdc_top_asserts.sv ***
/*
  Port checker for the sinc3 decimator top, bound into sdc_top.
  Assumes the map header and one clock with synchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sdc_map.svh"

module sdc_top_asserts
  import sdc_pkg::*;
(
  // Clock and reset.
  input wire logic       clk_sys,
  input wire logic       srst,
  // Register port.
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdData,
  // Clock pin and strobes.
  input wire logic       clock_source_strap,
  input wire logic       clkPinOut,
  input wire logic       clkPinOe,
  input wire logic       newData,
  input wire logic       outValid
);
  // System cycles per modulator tick for either master clock.
  localparam int MOD_CLKS = 2 * `SDC_OSC_HALF_LO * `SDC_MOD_DIV_LO;
  logic        run_q, run_d;
  logic        clean_q, clean_d;
  logic        strap_q;
  logic [2:0]  rate_q, rate_d;
  logic [19:0] since_q, since_d;
  logic [19:0] gap_q, gap_d;
  int          per;

  // Output period in system cycles for the mirrored rate code.
  assign per = ((rate_q > 3'd5) ? 16 : (1024 >> rate_q)) * MOD_CLKS;

  // Mirrors start and rate, counts cycles since a restart and since the last strobe.
  always_comb
  begin
    run_d   = run_q;
    rate_d  = rate_q;
    since_d = since_q + {19'h0, ~&since_q};
    gap_d   = gap_q + {19'h0, ~&gap_q};
    clean_d = clean_q && !regWr && (strap_q == clock_source_strap);
    if (regWr && regAddr == `SDC_ADDR_CONTROL)
    begin
      run_d = regWrData[`SDC_CTL_START];
      if (!run_q)
        since_d = 20'h0;
    end
    if (regWr && regAddr == `SDC_ADDR_CONFIG)
    begin
      rate_d = regWrData[2:0];
      if (rate_d != rate_q)
        since_d = 20'h0;
    end
    if (newData)
    begin
      gap_d   = 20'h1;
      clean_d = !regWr;
    end
  end

  // Registers the mirrors; the rate code resets to 2.
  always_ff @(posedge clk_sys)
  begin
    strap_q <= clock_source_strap;
    if (srst)
    begin
      run_q   <= 1'b0;
      rate_q  <= 3'd2;
      since_q <= 20'h0;
      gap_q   <= 20'h0;
      clean_q <= 1'b0;
    end
    else
    begin
      run_q   <= run_d;
      rate_q  <= rate_d;
      since_q <= since_d;
      gap_q   <= gap_d;
      clean_q <= clean_d;
    end
  end

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  AST_EXT_NO_DRIVE: assert property (!clock_source_strap |-> !clkPinOe)
    else $error("clock pin driven while the external clock is strapped");
  AST_OSC_DRIVE: assert property ((regWr && regAddr == `SDC_ADDR_CONFIG && regWrData[5]
    && clock_source_strap) ##1 clock_source_strap |-> clkPinOe)
    else $error("clock pin not driven after enable was set");
  AST_OSC_OFF: assert property (regWr && regAddr == `SDC_ADDR_CONFIG && !regWrData[5] |=> !clkPinOe)
    else $error("clock pin driven after enable was cleared");
  AST_TRISTATE_LOW: assert property (!clkPinOe |-> !clkPinOut)
    else $error("clock pin level high while released");
  AST_LEAD_BITS: assert property (regRd && regAddr == `SDC_ADDR_LEADSTAT |=> (regRdData & 8'hbf) == 8'h00)
    else $error("lead status shows bits other than frequency select");
  AST_STROBE_PULSE: assert property (newData |=> !newData)
    else $error("new data strobe longer than one cycle");
  AST_STROBE_FIFO: assert property (newData && !outValid |=> outValid)
    else $error("strobed word missing from the stream");
  AST_NO_START: assert property (!run_q [*3] |-> !newData)
    else $error("output while conversion stopped");
  AST_SETTLE_WAIT: assert property (newData |-> since_q >= 3 * per - MOD_CLKS)
    else $error("output before three output periods of settling");
  AST_OUTPUT_GAP: assert property (newData && clean_q |-> gap_q == per)
    else $error("output spacing differs from the decimation period");

  cover property (newData && clean_q);
  cover property (regRd && regAddr == `SDC_ADDR_LEADSTAT);
  cover property (clkPinOe);
endmodule

bind sdc_top sdc_top_asserts u_chk (.clk_sys, .srst, .regAddr, .regWrData, .regWr, .regRd,
  .regRdData, .clock_source_strap, .clkPinOut, .clkPinOe, .newData, .outValid);

`default_nettype wire

// *** test/sdc_partner.sv ***
/*
  Far side model: modulator bitstreams, external master clock and stream consumer.
  Assumes the bench sets pattern, clock enable and stall.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sdc_map.svh"

module sdc_partner
  import sdc_pkg::*;
(
  // Clock.
  input wire logic       clk_sys,
  // Controls from the bench.
  input wire logic [1:0] pattern,
  input wire logic       extOn,
  input wire logic       stall,
  // Device side.
  input wire logic       clkPinOut,
  input wire logic       clkPinOe,
  output logic           clkPinIn,
  output logic [1:0]     modBits,
  output logic           outReady
);
  logic [4:0] div_q   = 5'd0;
  logic       ext_q   = 1'b0;
  logic       float_q = 1'b0;

  // External clock near 512 kHz; it stops entirely when switched off.
  always @(posedge clk_sys)
  begin
    float_q <= ~float_q;
    if (extOn)
    begin
      div_q <= (div_q == 5'(`SDC_OSC_HALF_LO - 1)) ? 5'd0 : div_q + 5'd1;
      if (div_q == 5'(`SDC_OSC_HALF_LO - 1))
        ext_q <= ~ext_q;
    end
  end

  // Pin: the device driver wins, then the external source, else an undriven wobble.
  assign clkPinIn = clkPinOe ? clkPinOut : (extOn ? ext_q : float_q);
  assign modBits  = pattern;
  assign outReady = !stall;
endmodule

`default_nettype wire

// *** test/test_sdc_top.sv ***
/*
  Self-checking bench for sdc_top with the far side model.
  Assumes the checker is bound and a 40 ns clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sdc_map.svh"

module test_sdc_top
  import sdc_pkg::*;
;
  logic        clk_sys            = 1'b0;
  logic        srst               = 1'b1;
  logic [3:0]  regAddr            = 4'h0;
  logic [7:0]  regWrData          = 8'h00;
  logic        regWr              = 1'b0;
  logic        regRd              = 1'b0;
  logic        clock_source_strap = 1'b1;
  logic        extOn              = 1'b0;
  logic        stall              = 1'b0;
  logic        rdSeen             = 1'b0;
  logic [1:0]  pattern            = 2'b00;
  logic [31:0] rnd                = 32'h129211f3;
  logic [7:0]  regRdData;
  logic        clkPinIn;
  logic        clkPinOut;
  logic        clkPinOe;
  logic        newData;
  logic        outValid;
  logic        outReady;
  logic [1:0]  modBits;
  logic [31:0] outData;
  logic [15:0] regQ[$];
  logic [31:0] outQ[$];
  int          n_fail   = 0;
  int          compares = 0;
  int          nd       = 0;

  sdc_top u_dut (.clk_sys, .srst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .clock_source_strap, .clkPinIn, .clkPinOut, .clkPinOe, .modBits, .newData,
    .outValid, .outReady, .outData);
  sdc_partner u_far (.clk_sys, .pattern, .extOn, .stall, .clkPinOut, .clkPinOe,
    .clkPinIn, .modBits, .outReady);

  initial forever #20 clk_sys = ~clk_sys;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
    #1;
  endtask

  // Notes the masked expectation, then reads once.
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    regQ.push_back({m, e & m});
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
  endtask

  // One run with a constant bitstream, optionally changing rate after the first word.
  task automatic run(input logic [1:0] p, input logic s, input logic f, input logic [2:0] code,
                     input int words, input bit chg);
    int t;
    clock_source_strap <= s;
    extOn              <= !s;
    pattern            <= p;
    wr(`SDC_ADDR_LEADSTAT, {1'b0, f, 6'h00});
    wr(`SDC_ADDR_CONFIG, {5'b00100, code});
    chk("clkPinOe", {31'h0, s}, {31'h0, clkPinOe});
    t = nd;
    repeat (words) outQ.push_back({p[0] ? 16'h7fff : 16'h8000, p[1] ? 16'h7fff : 16'h8000});
    wr(`SDC_ADDR_CONTROL, 8'h01);
    for (int i = 0; i < 40000 && nd < t + 1; i++) @(posedge clk_sys);
    if (chg)
      wr(`SDC_ADDR_CONFIG, {5'b00100, code ^ 3'd1});
    for (int i = 0; i < 40000 && nd < t + words; i++) @(posedge clk_sys);
    wr(`SDC_ADDR_CONTROL, 8'h00);
    for (int i = 0; i < 200 && outValid !== 1'b0; i++) @(posedge clk_sys);
    chk("pending", 32'h0, 32'(outQ.size()));
    rd(`SDC_ADDR_STATUS, 8'h04, 8'h04);
  endtask

  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Random stalls; read data and stream words checked against the queues.
  always @(posedge clk_sys)
  begin
    rnd   <= xs(rnd);
    stall <= rnd[0] & rnd[1];
    if (rdSeen && regQ.size() > 0)
    begin
      chk("regRdData", {24'h0, regQ[0][7:0]}, {24'h0, regRdData & regQ[0][15:8]});
      void'(regQ.pop_front());
    end
    rdSeen <= regRd;
    if (newData === 1'b1)
      nd++;
    if (outValid === 1'b1 && outReady === 1'b1)
      chk("outData", (outQ.size() > 0) ? outQ.pop_front() : 32'hx, outData);
  end

  // Main sequence.
  initial
  begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    rd(`SDC_ADDR_CONFIG, 8'hff, `SDC_CFG_RESET);
    rd(`SDC_ADDR_LEADSTAT, 8'hff, 8'h00);
    chk("clkPinOe", 32'h0, {31'h0, clkPinOe});
    for (int c = 0; c < 8; c++)
    begin
      wr(`SDC_ADDR_CONFIG, 8'h20 | 8'(c));
      rd(`SDC_ADDR_CONFIG, 8'h27, 8'h20 | 8'(c));
    end
    chk("clkPinOe", 32'h1, {31'h0, clkPinOe});
    wr(`SDC_ADDR_CONFIG, 8'h06);
    chk("clkPinOe", 32'h0, {31'h0, clkPinOe});
    wr(`SDC_ADDR_LEADSTAT, 8'h40);
    rd(`SDC_ADDR_LEADSTAT, 8'hff, 8'h40);
    wr(4'h5, rnd[7:0]);
    rd(4'h5, 8'hff, 8'h00);
    run(2'b11, 1'b1, 1'b0, 3'd6, 2, 1'b0);
    run(2'b00, 1'b1, 1'b1, 3'd6, 2, 1'b0);
    run(2'b01, 1'b0, 1'b0, 3'd7, 3, 1'b1);
    end_of_test();
  end

  // Cuts a hang short.
  initial
  begin
    #(40 * 100000);
    n_fail++;
    end_of_test();
  end
endmodule

`default_nettype wire
